// >>> inc/move_exec_pkg.sv
// constants and types for the data-move execution unit
// Summary of operation
// - control register move runs only in supervisor state, else privilege trap
// - control register move is 32 bits; unimplemented bits read as zero
// - opcode bit 0: 0 copies control to general, 1 general to control
// - extension bit 15 picks data or address, then number, low 12 bits code
// - codes 000, 001, 800, 801 pick the four control registers
// - any other control code raises illegal instruction, no transfer
// - multi move transfers masked registers only, word or long per size bit
// - multi move word loads are sign-extended to 32 bits before register write
// - control modes step address up by 2 or 4, D0..D7 then A0..A7
// - predecrement stores only, first at address minus length, A7..A0 then D7..D0
// - predecrement leaves last stored address; stored base register shows final value
// - postincrement loads only; base ends last plus length, loaded base gets value plus length
// - store modes: indirect, predecrement, displacement, indexed, absolute
// - load modes: indirect, postincrement, displacement, indexed, absolute, pc-relative
// - multi move opcode holds direction and size bits; mask in next word
// - mask bit 0 is D0 normally, A7 in predecrement mode
// - every multi move ends with one extra read one step beyond
// - peripheral move steps by two, most significant byte first
// - peripheral address is register plus signed 16-bit offset; odd uses low lane
// - long peripheral move does four bytes, word move two
// - peripheral opmode 100..111 picks word/long and direction
`default_nettype none
package move_exec_pkg;
   localparam logic [11:0] CR_SRC_SPACE = 12'h000;
   localparam logic [11:0] CR_DST_SPACE = 12'h001;
   localparam logic [11:0] CR_USER_SP = 12'h800;
   localparam logic [11:0] CR_VEC_BASE = 12'h801;
   localparam logic [2:0] SPACE_RESET = 3'h0;
   localparam logic [31:0] WORD_RESET = 32'h0;
   localparam logic [14:0] CRMOVE_OPC = 15'h273d;
   localparam logic [4:0] MM_OPC_HI = 5'h09;
   localparam logic [2:0] MM_OPC_MID = 3'h1;
   localparam logic [3:0] MP_OPC_HI = 4'h0;
   localparam logic [2:0] MP_EA_MODE = 3'h1;
   localparam int DIR_BIT = 0;
   localparam int AD_BIT = 15;
   localparam int MM_DIR_BIT = 10;
   localparam int MM_SIZE_BIT = 6;
   localparam int MP_LOAD_BIT = 7;
   localparam int MP_LONG_BIT = 6;
   localparam logic [2:0] M_IND = 3'h2;
   localparam logic [2:0] M_POST = 3'h3;
   localparam logic [2:0] M_PRE = 3'h4;
   localparam logic [2:0] M_DISP = 3'h5;
   localparam logic [2:0] M_IDX = 3'h6;
   localparam logic [2:0] M_EXT = 3'h7;
   localparam logic [2:0] R_ABSW = 3'h0;
   localparam logic [2:0] R_ABSL = 3'h1;
   localparam logic [2:0] R_PCD = 3'h2;
   localparam logic [2:0] R_PCX = 3'h3;
   localparam logic [31:0] MP_STEP = 32'h2;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} bus_size_t;
   typedef struct packed {
      logic we;
      logic [31:0] addr;
      bus_size_t size;
      logic [31:0] wdata;
   } bus_cmd_t;
   typedef struct packed {
      logic we;
      logic [3:0] idx;
      logic [31:0] data;
   } rf_wr_t;
endpackage : move_exec_pkg
`default_nettype wire

// >>> logic/move_exec.sv
// execution unit for control, multiple and peripheral register moves
`timescale 1ns/1ps
`default_nettype none
module move_exec import move_exec_pkg::*; (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // instruction issue
   input wire logic start,
   input wire logic [15:0] op_word,
   input wire logic [15:0] ext_word,
   input wire logic supervisor,
   input wire logic [31:0] ea_addr,
   output logic busy,
   output logic done,
   output logic trap_priv,
   output logic trap_illegal,
   // general register file
   output logic [3:0] rf_raddr,
   input wire logic [31:0] rf_rdata,
   output rf_wr_t rf_wr,
   // processor bus
   output logic bus_req,
   output bus_cmd_t bus_cmd,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_ack
);
   typedef enum {S_IDLE, S_MM_SCAN, S_MM_BUS, S_MM_EXTRA, S_MM_FIN,
      S_MP_SCAN, S_MP_BUS, S_MP_FIN} state_t;

   function automatic logic [4:0] popcount(input logic [15:0] m);
      logic [4:0] c;
      c = 5'h0;
      for (int i = 0; i < 16; i++) begin
         c = c + 5'(m[i]);
      end
      return c;
   endfunction : popcount

   function automatic logic mode_ok(input logic load, input logic [2:0] m, input logic [2:0] r);
      if (m == M_EXT) begin
         return r == R_ABSW || r == R_ABSL || (load && (r == R_PCD || r == R_PCX));
      end
      return m == M_IND || m == M_DISP || m == M_IDX || (load ? m == M_POST : m == M_PRE);
   endfunction : mode_ok

   state_t state_r;
   logic [2:0] src_space_r;
   logic [2:0] dst_space_r;
   logic [31:0] user_sp_r;
   logic [31:0] vec_base_r;
   logic [15:0] mask_r;
   logic [4:0] idx_r;
   logic [31:0] addr_r;
   logic [31:0] final_r;
   logic load_r;
   logic long_r;
   logic pre_r;
   logic post_r;
   logic [2:0] base_r;
   logic base_loaded_r;
   logic [1:0] mp_cnt_r;
   logic [31:0] mp_data_r;
   logic [2:0] dreg_r;

   // decode at issue
   wire is_cr = op_word[15:1] == CRMOVE_OPC;
   wire is_mm = op_word[15:11] == MM_OPC_HI && op_word[9:7] == MM_OPC_MID;
   wire is_mp = op_word[15:12] == MP_OPC_HI && op_word[8] && op_word[5:3] == MP_EA_MODE;
   wire [11:0] cr_code = ext_word[11:0];
   wire cr_ok = cr_code == CR_SRC_SPACE || cr_code == CR_DST_SPACE
      || cr_code == CR_USER_SP || cr_code == CR_VEC_BASE;
   wire cr_go = start && is_cr && supervisor && cr_ok;
   wire cr_to_ctl = op_word[DIR_BIT];
   wire mm_load = op_word[MM_DIR_BIT];
   wire mm_long = op_word[MM_SIZE_BIT];
   wire mm_ok = mode_ok(mm_load, op_word[5:3], op_word[2:0]);
   wire [31:0] mm_len = mm_long ? 32'h4 : 32'h2;
   wire [31:0] cr_rd = cr_code == CR_SRC_SPACE ? 32'(src_space_r)
      : cr_code == CR_DST_SPACE ? 32'(dst_space_r)
      : cr_code == CR_USER_SP ? user_sp_r : vec_base_r;

   // sequencing helpers
   wire [31:0] len = long_r ? 32'h4 : 32'h2;
   wire [3:0] cur_reg = pre_r ? ~idx_r[3:0] : idx_r[3:0];
   wire [3:0] base_idx = {1'b1, base_r};
   wire is_base = cur_reg == base_idx;
   wire [31:0] st_val = (pre_r && is_base) ? final_r : rf_rdata;
   wire [31:0] st_data = long_r ? st_val : {16'h0, st_val[15:0]};
   wire [31:0] ld_val = long_r ? bus_rdata : 32'(signed'(bus_rdata[15:0]));
   wire [31:0] mp_sh = rf_rdata >> {mp_cnt_r, 3'b000};
   wire [7:0] mp_byte = mp_sh[7:0];
   wire [7:0] mp_in = addr_r[0] ? bus_rdata[7:0] : bus_rdata[15:8];
   wire [31:0] mp_out = addr_r[0] ? {24'h0, mp_byte} : {16'h0, mp_byte, 8'h00};

   assign busy = state_r != S_IDLE;
   assign bus_req = state_r == S_MM_BUS || state_r == S_MM_EXTRA || state_r == S_MP_BUS;
   assign rf_raddr = (state_r == S_IDLE) ? (is_mp ? {1'b1, op_word[2:0]} : ext_word[15:12])
      : (state_r == S_MM_SCAN) ? cur_reg : {1'b0, dreg_r};

   // condition flags have no path out of this unit at all
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_IDLE;
         src_space_r <= SPACE_RESET;
         dst_space_r <= SPACE_RESET;
         user_sp_r <= WORD_RESET;
         vec_base_r <= WORD_RESET;
         mask_r <= 16'h0;
         idx_r <= 5'h0;
         addr_r <= WORD_RESET;
         final_r <= WORD_RESET;
         load_r <= 1'b0;
         long_r <= 1'b0;
         pre_r <= 1'b0;
         post_r <= 1'b0;
         base_r <= 3'h0;
         base_loaded_r <= 1'b0;
         mp_cnt_r <= 2'h0;
         mp_data_r <= WORD_RESET;
         dreg_r <= 3'h0;
         done <= 1'b0;
         trap_priv <= 1'b0;
         trap_illegal <= 1'b0;
         rf_wr <= '0;
         bus_cmd <= '0;
      end else begin
         done <= 1'b0;
         trap_priv <= 1'b0;
         trap_illegal <= 1'b0;
         rf_wr.we <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (start && is_cr && !supervisor) begin
                  trap_priv <= 1'b1;
               end else if (start && is_cr && !cr_ok) begin
                  trap_illegal <= 1'b1;
               end else if (cr_go && cr_to_ctl) begin
                  if (cr_code == CR_SRC_SPACE) src_space_r <= rf_rdata[2:0];
                  if (cr_code == CR_DST_SPACE) dst_space_r <= rf_rdata[2:0];
                  if (cr_code == CR_USER_SP) user_sp_r <= rf_rdata;
                  if (cr_code == CR_VEC_BASE) vec_base_r <= rf_rdata;
                  done <= 1'b1;
               end else if (cr_go) begin
                  rf_wr <= '{we: 1'b1, idx: ext_word[15:12], data: cr_rd};
                  done <= 1'b1;
               end else if (start && is_mm && !mm_ok) begin
                  trap_illegal <= 1'b1;
               end else if (start && is_mm) begin
                  mask_r <= ext_word;
                  idx_r <= 5'h0;
                  load_r <= mm_load;
                  long_r <= mm_long;
                  pre_r <= op_word[5:3] == M_PRE;
                  post_r <= op_word[5:3] == M_POST;
                  base_r <= op_word[2:0];
                  base_loaded_r <= 1'b0;
                  addr_r <= (op_word[5:3] == M_PRE) ? ea_addr - mm_len : ea_addr;
                  final_r <= ea_addr - (32'(popcount(ext_word)) << (mm_long ? 2 : 1));
                  state_r <= S_MM_SCAN;
               end else if (start && is_mp) begin
                  addr_r <= rf_rdata + 32'(signed'(ext_word));
                  load_r <= !op_word[MP_LOAD_BIT];
                  long_r <= op_word[MP_LONG_BIT];
                  mp_cnt_r <= op_word[MP_LONG_BIT] ? 2'h3 : 2'h1;
                  mp_data_r <= WORD_RESET;
                  dreg_r <= op_word[11:9];
                  state_r <= S_MP_SCAN;
               end else if (start) begin
                  trap_illegal <= 1'b1;
               end
            end
            S_MM_SCAN: begin
               if (idx_r[4]) begin
                  bus_cmd <= '{we: 1'b0, addr: addr_r, size: long_r ? SZ_LONG : SZ_WORD, wdata: 32'h0};
                  state_r <= S_MM_EXTRA;
               end else if (mask_r[idx_r[3:0]]) begin
                  bus_cmd <= '{we: !load_r, addr: addr_r, size: long_r ? SZ_LONG : SZ_WORD, wdata: st_data};
                  state_r <= S_MM_BUS;
               end else begin
                  idx_r <= idx_r + 5'h1;
               end
            end
            S_MM_BUS: begin
               if (bus_ack) begin
                  if (load_r) begin
                     rf_wr <= '{we: 1'b1, idx: cur_reg, data: (post_r && is_base) ? ld_val + len : ld_val};
                     if (post_r && is_base) base_loaded_r <= 1'b1;
                  end
                  addr_r <= pre_r ? addr_r - len : addr_r + len;
                  idx_r <= idx_r + 5'h1;
                  state_r <= S_MM_SCAN;
               end
            end
            S_MM_EXTRA: begin
               // fetched data is dropped; the cycle only mirrors the prefetch
               if (bus_ack) state_r <= S_MM_FIN;
            end
            S_MM_FIN: begin
               if (pre_r) begin
                  rf_wr <= '{we: 1'b1, idx: base_idx, data: addr_r + len};
               end else if (post_r && !base_loaded_r) begin
                  rf_wr <= '{we: 1'b1, idx: base_idx, data: addr_r};
               end
               done <= 1'b1;
               state_r <= S_IDLE;
            end
            S_MP_SCAN: begin
               bus_cmd <= '{we: !load_r, addr: addr_r, size: SZ_BYTE, wdata: mp_out};
               state_r <= S_MP_BUS;
            end
            S_MP_BUS: begin
               if (bus_ack) begin
                  if (load_r) mp_data_r <= {mp_data_r[23:0], mp_in};
                  addr_r <= addr_r + MP_STEP;
                  mp_cnt_r <= mp_cnt_r - 2'h1;
                  state_r <= (mp_cnt_r == 2'h0) ? S_MP_FIN : S_MP_SCAN;
               end
            end
            S_MP_FIN: begin
               // word loads keep the upper half of the data register
               if (load_r) begin
                  rf_wr <= '{we: 1'b1, idx: {1'b0, dreg_r},
                     data: long_r ? mp_data_r : {rf_rdata[31:16], mp_data_r[15:0]}};
               end
               done <= 1'b1;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_priv;
      start && !busy && is_cr && !supervisor |=> trap_priv && !rf_wr.we && !done;
   endproperty
   a_priv: assert property (p_priv) else $error("user mode control move not trapped");

   property p_cr_bad;
      start && !busy && is_cr && supervisor && !cr_ok |=> trap_illegal && !rf_wr.we;
   endproperty
   a_cr_bad: assert property (p_cr_bad) else $error("bad control code not trapped");

   property p_cr_zero;
      cr_go && !busy && !cr_to_ctl && !cr_code[11] |=> rf_wr.we && rf_wr.data[31:3] == 29'h0;
   endproperty
   a_cr_zero: assert property (p_cr_zero) else $error("space code upper bits not zero");

   property p_cr_write;
      cr_go && !busy && cr_to_ctl && cr_code == CR_VEC_BASE |=> vec_base_r == $past(rf_rdata);
   endproperty
   a_cr_write: assert property (p_cr_write) else $error("vector base not written");

   property p_mm_bad;
      start && !busy && !is_cr && is_mm && !mm_ok |=> trap_illegal && !busy;
   endproperty
   a_mm_bad: assert property (p_mm_bad) else $error("illegal multi move mode accepted");

   property p_step;
      state_r == S_MM_BUS && bus_ack && !pre_r |=> addr_r == $past(addr_r) + len;
   endproperty
   a_step: assert property (p_step) else $error("multi move address step wrong");

   property p_pre_store;
      state_r == S_MM_BUS && pre_r |-> bus_cmd.we;
   endproperty
   a_pre_store: assert property (p_pre_store) else $error("predecrement load issued");

   property p_extra;
      state_r == S_MM_SCAN && idx_r[4] |=> bus_req && !bus_cmd.we && bus_cmd.addr == $past(addr_r);
   endproperty
   a_extra: assert property (p_extra) else $error("extra read missing");

   property p_sext;
      state_r == S_MM_BUS && bus_ack && load_r && !long_r && !post_r |=> rf_wr.data == $past(ld_val)
         && rf_wr.data[31:16] == {16{rf_wr.data[15]}};
   endproperty
   a_sext: assert property (p_sext) else $error("word load not sign-extended");

   sequence s_mp_ack;
      state_r == S_MP_BUS && bus_ack && mp_cnt_r != 2'h0;
   endsequence
   sequence s_mp_next;
      ##2 state_r == S_MP_BUS && bus_cmd.addr == $past(bus_cmd.addr, 2) + MP_STEP;
   endsequence
   property p_mp_step;
      s_mp_ack |-> s_mp_next;
   endproperty
   a_mp_step: assert property (p_mp_step) else $error("peripheral step not two");

   property p_lane;
      state_r == S_MP_BUS && bus_cmd.addr[0] |-> bus_cmd.size == SZ_BYTE && bus_cmd.wdata[15:8] == 8'h0;
   endproperty
   a_lane: assert property (p_lane) else $error("odd peripheral byte on wrong lane");
endmodule : move_exec
`default_nettype wire

// >>> testbench/bus_partner.sv
// memory and peripheral model on the processor bus
`timescale 1ns/1ps
`default_nettype none
module bus_partner import move_exec_pkg::*; (
   // clock
   input wire logic clock,
   // processor bus
   input wire logic bus_req,
   input wire bus_cmd_t bus_cmd,
   output logic [31:0] bus_rdata,
   output logic bus_ack,
   // wait states before each ack
   input wire logic [3:0] delay
);
   bus_cmd_t log_q[$];
   logic [3:0] cnt = 4'h0;
   logic ack_r = 1'b0;
   logic [31:0] data_r = 32'h0;
   assign bus_ack = ack_r;
   assign bus_rdata = data_r;
   // data toggles outside ack so stale data never passes for a fetch
   always @(posedge clock) begin
      ack_r <= 1'b0;
      data_r <= ~data_r;
      if (bus_req && !ack_r) begin
         if (cnt == delay) begin
            cnt <= 4'h0;
            ack_r <= 1'b1;
            data_r <= {~bus_cmd.addr[15:0], ~bus_cmd.addr[15:0]};
            log_q.push_back(bus_cmd);
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : bus_partner
`default_nettype wire

// >>> testbench/move_control_multiple_peripheral_exec_bench.sv
// self-checking bench for the data-move execution unit
`timescale 1ns/1ps
`default_nettype none
module move_control_multiple_peripheral_exec_bench import move_exec_pkg::*;;
   logic clock, resetn, start, supervisor, busy, done, trap_priv, trap_illegal, bus_req, bus_ack;
   logic [15:0] op_word, ext_word;
   logic [31:0] ea_addr, rf_rdata, bus_rdata;
   logic [3:0] rf_raddr, delay;
   rf_wr_t rf_wr;
   bus_cmd_t bus_cmd;
   int mismatches, num_checks;
   logic [31:0] regs [16];
   logic [1:0] outcome;
   logic saw_busy;
   logic [11:0] codes [4] = '{12'h000, 12'h001, 12'h800, 12'h801};
   logic [15:0] bad [4] = '{16'h489a, 16'h4880, 16'h4ca1, 16'h4cbc};

   move_exec DUT (.clock(clock), .resetn(resetn), .start(start), .op_word(op_word), .ext_word(ext_word),
      .supervisor(supervisor), .ea_addr(ea_addr), .busy(busy), .done(done), .trap_priv(trap_priv),
      .trap_illegal(trap_illegal), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_wr(rf_wr),
      .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_rdata(bus_rdata), .bus_ack(bus_ack));
   bus_partner mem (.clock(clock), .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_rdata(bus_rdata),
      .bus_ack(bus_ack), .delay(delay));

   // register file answers in the same cycle
   assign rf_rdata = regs[rf_raddr];
   always @(posedge clock) if (rf_wr.we === 1'b1) regs[rf_wr.idx] <= rf_wr.data;

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value %s exp %h got %h", name, exp, got);
         mismatches++;
      end
   endtask : check

   task chk_bus(input int i, input logic we, input logic [31:0] addr, input logic [31:0] wd, input logic [31:0] m);
      if (i >= mem.log_q.size()) begin
         check("bus cycles", 32'(i + 1), 32'(mem.log_q.size()));
      end else begin
         check("bus we", {31'h0, we}, {31'h0, mem.log_q[i].we});
         check("bus addr", addr, mem.log_q[i].addr);
         check("bus data", wd & m, mem.log_q[i].wdata & m);
      end
   endtask : chk_bus

   // issue one instruction and wait for its end under a bound
   task issue(input logic [15:0] op, input logic [15:0] ext, input logic sup, input logic [31:0] ea);
      mem.log_q.delete();
      @(posedge clock);
      start <= 1'b1;
      op_word <= op;
      ext_word <= ext;
      supervisor <= sup;
      ea_addr <= ea;
      @(posedge clock);
      start <= 1'b0;
      outcome = 2'd3;
      saw_busy = 1'b0;
      for (int i = 0; i < 400 && outcome == 2'd3; i++) begin
         #1;
         if (busy === 1'b1) saw_busy = 1'b1;
         if (done === 1'b1) outcome = 2'd0;
         else if (trap_priv === 1'b1) outcome = 2'd1;
         else if (trap_illegal === 1'b1) outcome = 2'd2;
         else @(posedge clock);
      end
      if (outcome == 2'd3) begin
         check("completion", 32'h0, 32'h3);
         give_verdict();
      end
      check("busy at end", 32'h0, {31'h0, busy});
      // base writeback lands after done
      repeat (2) @(posedge clock);
      #1;
   endtask : issue

   initial begin
      resetn = 1'b0;
      start = 1'b0;
      op_word = 16'h0;
      ext_word = 16'h0;
      supervisor = 1'b0;
      ea_addr = 32'h0;
      delay = 4'h0;
      mismatches = 0;
      num_checks = 0;
      for (int k = 0; k < 16; k++) regs[k] = 32'h0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      regs[1] = 32'h87654329;
      foreach (codes[k]) begin
         issue(16'h4e7b, {1'b0, 3'd1, codes[k]}, 1'b1, 32'h0);
         issue(16'h4e7a, {1'b1, 3'd2, codes[k]}, 1'b1, 32'h0);
         check("ctrl read", codes[k][11] ? regs[1] : 32'h1, regs[10]);
         check("ctrl busy", 32'h0, {31'h0, saw_busy});
      end
      issue(16'h7000, 16'h0000, 1'b1, 32'h0);
      check("unknown op", 32'h2, {30'h0, outcome});
      regs[10] = 32'h0;
      issue(16'h4e7a, {1'b1, 3'd2, 12'h800}, 1'b0, 32'h0);
      check("priv trap", 32'h1, {30'h0, outcome});
      check("no write", 32'h0, regs[10]);
      issue(16'h4e7a, {1'b1, 3'd2, 12'h802}, 1'b1, 32'h0);
      check("bad code", 32'h2, {30'h0, outcome});
      regs[0] = 32'hcafe0001;
      issue(16'h48d0, 16'h0003, 1'b1, 32'h1000);
      check("multi busy", 32'h1, {31'h0, saw_busy});
      chk_bus(0, 1'b1, 32'h1000, regs[0], '1);
      chk_bus(1, 1'b1, 32'h1004, regs[1], '1);
      chk_bus(2, 1'b0, 32'h1008, 32'h0, 32'h0);
      check("bus count", 32'h3, 32'(mem.log_q.size()));
      // slow partner on the predecrement store
      delay = 4'h2;
      regs[9] = 32'h2000;
      regs[15] = 32'h0000beef;
      issue(16'h48a1, 16'h8041, 1'b1, 32'h2000);
      chk_bus(0, 1'b1, 32'h1ffe, 32'hbeef, 32'hffff);
      chk_bus(1, 1'b1, 32'h1ffc, 32'h1ffa, 32'hffff);
      chk_bus(2, 1'b1, 32'h1ffa, 32'h0001, 32'hffff);
      chk_bus(3, 1'b0, 32'h1ff8, 32'h0, 32'h0);
      check("pre base", 32'h1ffa, regs[9]);
      delay = 4'h0;
      regs[10] = 32'h3000;
      issue(16'h4c9a, 16'h0401, 1'b1, 32'h3000);
      check("sext load", 32'hffffcfff, regs[0]);
      check("post base", 32'hffffcfff, regs[10]);
      chk_bus(2, 1'b0, 32'h3004, 32'h0, 32'h0);
      regs[11] = 32'h3100;
      issue(16'h4c9b, 16'h0002, 1'b1, 32'h3100);
      check("post end", 32'h3102, regs[11]);
      check("post data", 32'hffffceff, regs[1]);
      issue(16'h4cba, 16'h0004, 1'b1, 32'h6000);
      check("pc rel", 32'hffff9fff, regs[2]);
      foreach (bad[k]) begin
         issue(bad[k], 16'h0001, 1'b1, 32'h3000);
         check("bad mode", 32'h2, {30'h0, outcome});
         check("bad bus", 32'h0, 32'(mem.log_q.size()));
      end
      regs[3] = 32'ha1b2c3d4;
      regs[12] = 32'h4000;
      issue(16'h07cc, 16'hfffe, 1'b1, 32'h0);
      for (int k = 0; k < 4; k++) begin
         chk_bus(k, 1'b1, 32'h3ffe + 32'(2 * k), {16'h0, regs[3][31 - 8 * k -: 8], 8'h0}, 32'hff00);
      end
      check("per count", 32'h4, 32'(mem.log_q.size()));
      regs[5] = 32'h12345678;
      regs[14] = 32'h5001;
      issue(16'h0b0e, 16'h0002, 1'b1, 32'h0);
      check("per load", 32'h1234fcfa, regs[5]);
      chk_bus(1, 1'b0, 32'h5005, 32'h0, 32'h0);
      // even address long load takes the upper lane
      regs[13] = 32'h5000;
      issue(16'h0d4d, 16'h0000, 1'b1, 32'h0);
      check("per long load", 32'hafafafaf, regs[6]);
      chk_bus(3, 1'b0, 32'h5006, 32'h0, 32'h0);
      give_verdict();
   end
endmodule : move_control_multiple_peripheral_exec_bench
`default_nettype wire
